// ### hdl/pofs_edge.sv
// Rising edge detector for the comparator output
`timescale 1ns/1ns
`default_nettype none

module pofs_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in, pulse out
    input wire logic level_in,
    output logic level_q,
    output logic rise
);

    logic level_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_r <= pofs_pkg::CMP_RESET;
        end else begin
            level_r <= level_in;
        end
    end

    assign level_q = level_r;
    assign rise = level_in & ~level_r;

endmodule

`default_nettype wire

// ### hdl/pofs_pkg.sv
// Package for the forced output stop block: states, carriers and levels
package pofs_pkg;

    // Forced stop state machine
    typedef enum logic {
        ST_RUN,
        ST_STOPPED
    } pofs_state_e;

    // Pin drive carrier: level and output enable
    typedef struct packed {
        logic level;
        logic oe;
    } pofs_pin_s;

    // Inactive level of the LED drive pin (LED off)
    localparam logic OUT_INACTIVE = 1'h1;
    // Release the pin in reset (output enable low) instead of driving the fixed inactive level
    localparam logic FIXED_MODE_RESET = 1'h0;
    localparam logic CMP_RESET = 1'h0;

endpackage

// ### hdl/pofs_top.sv
// Forced output stop of one PWM output channel on over-current
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Stop forces pin to Hi-Z or fixed level in hardware only.
// - During a stop the LED drive output sits at its inactive level when FIXED_MODE is high, and is high impedance when it is low.
// - Comparator output is high above reference, low below it.
// - Comparator rising edge switches PWM output to high impedance, or to the fixed level when FIXED_MODE is high.
// - Release writes are ignored while the comparator output is high.
// - With comparator low, a release write resumes normal PWM output.
module pofs_top (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // PWM timer unit output before stop control
    input wire logic PWM_IN,
    // Current sense comparator result, high when over current
    input wire logic COMPARATOR_OUTPUT,
    // Stop control from software
    input wire logic STOP_RELEASE_TRIGGER,
    input wire logic FIXED_MODE,
    // Controlled pin pwm_output_ch0
    output logic PWM_OUTPUT_CH0_O,
    output logic PWM_OUTPUT_CH0_OE,
    // Status
    output logic STOP_ACTIVE,
    output logic STOP_ENTERED
);

    pofs_pkg::pofs_state_e state_r;
    pofs_pkg::pofs_state_e state_nxt;
    pofs_pkg::pofs_pin_s pin_r;
    pofs_pkg::pofs_pin_s pin_nxt;
    logic cmp_rise;
    logic entered_r;

    function automatic logic is_stopped(input pofs_pkg::pofs_state_e st);
        return st == pofs_pkg::ST_STOPPED;
    endfunction

    // The comparator itself is analog and outside; its sense is taken as given
    pofs_edge u_edge (
        .clk(MCLK),
        .rst(RST),
        .level_in(COMPARATOR_OUTPUT),
        .level_q(),
        .rise(cmp_rise)
    );

    // Release must see the live comparator level so a write during over-current is lost
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pofs_pkg::ST_RUN: begin
                if (cmp_rise) begin
                    state_nxt = pofs_pkg::ST_STOPPED;
                end
            end
            pofs_pkg::ST_STOPPED: begin
                if (STOP_RELEASE_TRIGGER && !COMPARATOR_OUTPUT) begin
                    state_nxt = pofs_pkg::ST_RUN;
                end else begin
                    state_nxt = pofs_pkg::ST_STOPPED;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_r <= pofs_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // A stop edge in the same cycle as a release keeps the stop; the edge wins
    always_comb begin
        pin_nxt.level = PWM_IN;
        pin_nxt.oe = 1'h1;
        if (is_stopped(state_nxt)) begin
            pin_nxt.level = pofs_pkg::OUT_INACTIVE;
            pin_nxt.oe = FIXED_MODE;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pin_r.level <= pofs_pkg::OUT_INACTIVE;
            pin_r.oe <= pofs_pkg::FIXED_MODE_RESET;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            entered_r <= 1'h0;
        end else begin
            entered_r <= !is_stopped(state_r) && is_stopped(state_nxt);
        end
    end

    assign PWM_OUTPUT_CH0_O = pin_r.level;
    assign PWM_OUTPUT_CH0_OE = pin_r.oe;
    assign STOP_ACTIVE = is_stopped(state_r);
    assign STOP_ENTERED = entered_r;

endmodule

`default_nettype wire

// ### test/pofs_sense.sv
// Current sense comparator of the LED power stage
`timescale 1ns/1ns
`default_nettype none
module pofs_sense (
    input wire logic [7:0] sense,
    input wire logic [7:0] vref,
    output wire logic cmp
);
    assign cmp = sense > vref;
endmodule
`default_nettype wire

// ### test/pofs_sva.sv
// Checker for the forced output stop block
`timescale 1ns/1ns
`default_nettype none
module pofs_sva (
    input wire logic MCLK, RST, PWM_IN, COMPARATOR_OUTPUT, STOP_RELEASE_TRIGGER, FIXED_MODE,
    input wire logic PWM_OUTPUT_CH0_O, PWM_OUTPUT_CH0_OE, STOP_ACTIVE, STOP_ENTERED
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_run;
        !STOP_ACTIVE ##1 !STOP_ACTIVE;
    endsequence
    sequence s_pulse;
        STOP_ENTERED ##1 !STOP_ENTERED;
    endsequence
    a_rise_stops: assert property ($rose(COMPARATOR_OUTPUT) |=> STOP_ACTIVE) else $error("no stop");
    a_stop_pin: assert property (STOP_ACTIVE |-> PWM_OUTPUT_CH0_O && PWM_OUTPUT_CH0_OE == FIXED_MODE)
        else $error("pin not parked");
    a_refuse_release: assert property (STOP_ACTIVE && COMPARATOR_OUTPUT |=> STOP_ACTIVE) else $error("left stop");
    a_stop_latched: assert property (STOP_ACTIVE && !STOP_RELEASE_TRIGGER |=> STOP_ACTIVE) else $error("unlatched");
    a_release_runs: assert property (STOP_ACTIVE && STOP_RELEASE_TRIGGER && !COMPARATOR_OUTPUT
        |=> !STOP_ACTIVE && PWM_OUTPUT_CH0_OE && PWM_OUTPUT_CH0_O == $past(PWM_IN)) else $error("no resume");
    a_run_follows: assert property (s_run |-> PWM_OUTPUT_CH0_OE && PWM_OUTPUT_CH0_O == $past(PWM_IN))
        else $error("pwm not passed");
    a_entry_pulse: assert property ($rose(STOP_ACTIVE) |-> s_pulse) else $error("bad entry pulse");
endmodule
bind pofs_top pofs_sva i_pofs_sva(.*);
`default_nettype wire

// ### test/test_pofs_top.sv
// Self-checking bench for the forced output stop block
`timescale 1ns/1ns
`default_nettype none
module test_pofs_top;
    logic mclk = 0, rst = 1, pwm = 0, trg = 0, fm = 0, o, oe, sa, se, cmp;
    logic st = 0, pc = 0, pend = 0, ep = 0, live = 0;
    logic [7:0] sense = 8'h00;
    int fail_count = 0, n_checks = 0;
    always #20 mclk = ~mclk;
    pofs_sense i_pofs_sense(.sense(sense), .vref(8'h80), .cmp(cmp));
    pofs_top i_pofs_top(.MCLK(mclk), .RST(rst), .PWM_IN(pwm), .COMPARATOR_OUTPUT(cmp), .STOP_RELEASE_TRIGGER(trg),
        .FIXED_MODE(fm), .PWM_OUTPUT_CH0_O(o), .PWM_OUTPUT_CH0_OE(oe), .STOP_ACTIVE(sa), .STOP_ENTERED(se));
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch pins expected %b seen %b", exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Reference model; edge register clears in reset so a high comparator at release stops
    always @(posedge mclk) begin
        pend = !rst && !st && cmp && !pc;
        if (rst) st = 0;
        else if (pend) st = 1;
        else if (st && trg && !cmp) st = 0;
        pc = !rst && cmp;
        ep = pwm;
        live = !rst;
    end
    always @(negedge mclk) begin
        if (live && !rst) chk({o, oe, sa, se}, {st ? 1'b1 : ep, st ? fm : 1'b1, st, pend});
    end
    initial begin
        void'($urandom(32'hE39D));
        for (int t = 0; t < 2; t++) begin
            // Mode only changes under reset, so a stop never sees it move
            rst = 1;
            fm = t[0];
            repeat (6) @(posedge mclk);
            #1 rst = 0;
            repeat (800) begin
                @(posedge mclk);
                #1 pwm = 1'($urandom);
                // Release comes far sooner than a second; the block keeps no time of its own
                trg = ($urandom % 6) == 0;
                if ($urandom % 8 == 0) sense = 8'($urandom);
            end
            $display("test %0d done", t);
        end
        summarize;
    end
endmodule
`default_nettype wire
